// ### core/pti_core.sv
/*
 * Proximity threshold interrupt logic: compares each measurement against
 * the high and low thresholds, filters crossings by persistence, keeps the
 * interrupt event flags and drives the active-low interrupt line.
 * Assumes measurements, thresholds, mode and the host register read
 * request all arrive synchronous to MCLK from the surrounding sensor logic.
 * THRESH_LOW is expected below THRESH_HIGH: with them swapped one sample
 * counts as both crossings and the near side wins the line in logic mode.
 */
//
// Function
// - Flag register at command 0xF9 holds a high-crossing flag, 1 on event.
// - Low-crossing flag sits in bit 8 of the flag register.
// - Low-crossing flag reads 0 when idle, 1 once recorded.
// - Interrupt line signals the host on high or low threshold crossings.
// - Logic mode and enable mode select how the interrupt line reacts.
// - Interrupt fires only after the configured consecutive crossing count; in enable mode a sunlight event also pulls the line low.
// - Sunlight protection flag sits in bit 12, 1 when such an event occurred.
// - In enable mode a flag register read clears pending crossing flags.
// - Logic mode: low on high crossing, high on low crossing, repeats ignored.
// - Persistence of one fires on the very first crossing.
`include "pti_params.svh"

module pti_core
(
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic MEAS_VALID,
   input wire logic [`PTI_DATA_W-1:0] MEAS_DATA,
   input wire logic [`PTI_DATA_W-1:0] THRESH_HIGH,
   input wire logic [`PTI_DATA_W-1:0] THRESH_LOW,
   input wire logic MODE_ENABLE,
   input wire logic [`PTI_PERS_W-1:0] CROSSING_PERSISTENCE_COUNT,
   input wire logic SUNLIGHT_EVENT,
   input wire logic RD_STROBE,
   input wire logic [`PTI_ADDR_W-1:0] RD_ADDR,
   output logic [`PTI_DATA_W-1:0] RD_DATA,
   output logic RD_VALID,
   output logic INT_N
);

   // -------------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------------
   function automatic logic is_flag_addr(input logic [`PTI_ADDR_W-1:0] a);
      is_flag_addr = (a == `PTI_FLAG_ADDR);
   endfunction

   function automatic logic [`PTI_DATA_W-1:0] pack_flags
   (
      input pti_pkg::pti_state_t s
   );
      logic [`PTI_DATA_W-1:0] v;
      v = '0;
      v[`PTI_NEAR_BIT] = s.near_event_flag;
      v[`PTI_FAR_BIT] = s.far_event_flag;
      v[`PTI_SUN_BIT] = s.sunlight_guard_flag;
      pack_flags = v;
   endfunction

   // Strict compare: a count equal to a threshold is no crossing
   function automatic logic crosses
   (
      input logic [`PTI_DATA_W-1:0] meas,
      input logic [`PTI_DATA_W-1:0] thresh,
      input logic above
   );
      if (above)
      begin
         crosses = (meas > thresh);
      end
      else
      begin
         crosses = (meas < thresh);
      end
   endfunction

   // Enable mode holds the line low while any flag waits for the host
   function automatic logic pending_level
   (
      input pti_pkg::pti_state_t s
   );
      pending_level = !(s.near_event_flag
                        || s.far_event_flag
                        || s.sunlight_guard_flag);
   endfunction

   // One place for the after-reset picture of every field
   function automatic pti_pkg::pti_state_t reset_state();
      pti_pkg::pti_state_t s;
      s.near_event_flag = `PTI_FLAG_RESET;
      s.far_event_flag = `PTI_FLAG_RESET;
      s.sunlight_guard_flag = `PTI_FLAG_RESET;
      s.last_dir = pti_pkg::DIR_NONE;
      s.int_n = `PTI_INT_N_RESET;
      s.rd_data = '0;
      s.rd_valid = 1'h0;
      reset_state = s;
   endfunction

   // -------------------------------------------------------------------
   // Crossing detection and persistence
   // -------------------------------------------------------------------
   logic [1:0] crossing;
   logic [1:0] fire;

   // Index 0 is the high (near) side, index 1 the low (far) side
   assign crossing[0] = crosses(MEAS_DATA, THRESH_HIGH, 1'h1);
   assign crossing[1] = crosses(MEAS_DATA, THRESH_LOW, 1'h0);

   // One counter per direction so a near run never feeds a far run
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_pers
         pti_persist u_pers
         (
            .clk(MCLK),
            .nrst(NRST),
            .meas_valid(MEAS_VALID),
            .crossing(crossing[gi]),
            .pers_sel(CROSSING_PERSISTENCE_COUNT),
            .fire(fire[gi])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // Flags, interrupt line and register read
   // -------------------------------------------------------------------
   pti_pkg::pti_state_t st_reg;
   pti_pkg::pti_state_t st_next;
   pti_pkg::pti_mode_t mode;
   logic near_ok;
   logic far_ok;
   logic flag_read;

   always_comb
   begin
      mode = MODE_ENABLE ? pti_pkg::MODE_ENABLE : pti_pkg::MODE_LOGIC;
      st_next = st_reg;
      st_next.rd_valid = RD_STROBE;
      flag_read = RD_STROBE && is_flag_addr(RD_ADDR);
      near_ok = fire[0];
      far_ok = fire[1];
      // Data show the flags before this cycle's clear takes effect
      st_next.rd_data = flag_read ? pack_flags(st_reg) : '0;

      unique case (mode)
         pti_pkg::MODE_LOGIC:
         begin
            // Same-direction repeats wait for the opposite crossing
            near_ok = fire[0] && (st_reg.last_dir != pti_pkg::DIR_NEAR);
            far_ok = fire[1] && (st_reg.last_dir != pti_pkg::DIR_FAR);
         end
         pti_pkg::MODE_ENABLE:
         begin
            if (flag_read)
            begin
               st_next.near_event_flag = 1'h0;
               st_next.far_event_flag = 1'h0;
            end
         end
      endcase

      if (flag_read)
      begin
         st_next.sunlight_guard_flag = 1'h0;
      end

      // Sets come last so an event in the clearing cycle is kept
      if (near_ok)
      begin
         st_next.near_event_flag = 1'h1;
         st_next.last_dir = pti_pkg::DIR_NEAR;
      end
      if (far_ok)
      begin
         st_next.far_event_flag = 1'h1;
         st_next.last_dir = pti_pkg::DIR_FAR;
      end
      if (SUNLIGHT_EVENT)
      begin
         st_next.sunlight_guard_flag = 1'h1;
      end

      unique case (mode)
         pti_pkg::MODE_LOGIC:
         begin
            // Level follows the direction of the latest accepted crossing
            if (near_ok)
            begin
               st_next.int_n = 1'h0;
            end
            else if (far_ok)
            begin
               st_next.int_n = 1'h1;
            end
         end
         pti_pkg::MODE_ENABLE:
         begin
            // Low while any flag is pending; the read releases it
            st_next.int_n = pending_level(st_next);
         end
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (!NRST)
      begin
         st_reg <= reset_state();
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign RD_DATA = st_reg.rd_data;
   assign RD_VALID = st_reg.rd_valid;
   assign INT_N = st_reg.int_n;

endmodule

// ### core/pti_params.svh
/*
 * Constants of the proximity threshold interrupt block: the flag register
 * command code, its field positions, reset values and the persistence code.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef PTI_PARAMS_SVH
`define PTI_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PTI_FLAG_ADDR 8'hF9
`define PTI_ADDR_W 8
`define PTI_DATA_W 16

// ----------------------------------------------------------------------
// Field positions inside interrupt_event_flags
// ----------------------------------------------------------------------
`define PTI_FAR_BIT 8
`define PTI_NEAR_BIT 9
`define PTI_SUN_BIT 12

// ----------------------------------------------------------------------
// Reset values and persistence coding
// ----------------------------------------------------------------------
`define PTI_FLAG_RESET 1'h0
`define PTI_INT_N_RESET 1'h1
`define PTI_PERS_W 2
`define PTI_CNT_W 3

`endif

// ### core/pti_persist.sv
/*
 * Consecutive crossing counter for one threshold direction.
 * Assumes one meas_valid pulse per finished measurement and that crossing
 * is valid in that cycle. fire is a one-cycle registered pulse.
 */
`include "pti_params.svh"

module pti_persist
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic meas_valid,
   input wire logic crossing,
   input wire logic [`PTI_PERS_W-1:0] pers_sel,
   output logic fire
);

   pti_pkg::pti_pers_state_t st_reg;
   pti_pkg::pti_pers_state_t st_next;
   logic [`PTI_CNT_W-1:0] target;
   logic [`PTI_CNT_W-1:0] bumped;

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      // Code 0..3 stands for a count of 1..4
      target = {1'h0, pers_sel} + 3'h1;
      bumped = st_reg.count + 3'h1;
      st_next = st_reg;
      st_next.fire = 1'h0;
      if (meas_valid)
      begin
         if (crossing)
         begin
            // Saturate so a long run fires once only
            if (st_reg.count < target)
            begin
               st_next.count = bumped;
               st_next.fire = (bumped == target);
            end
         end
         else
         begin
            // A non-crossing measurement breaks the run
            st_next.count = 3'h0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign fire = st_reg.fire;

endmodule

// ### core/pti_pkg.sv
/*
 * Types shared by the proximity threshold interrupt modules.
 * Assumes pti_params.svh sits in the include path.
 */
`include "pti_params.svh"

package pti_pkg;

   // -------------------------------------------------------------------
   // Enumerations
   // -------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_LOGIC  = 2'h1,
      MODE_ENABLE = 2'h2
   } pti_mode_t;

   typedef enum logic [2:0]
   {
      DIR_NONE = 3'h1,
      DIR_NEAR = 3'h2,
      DIR_FAR  = 3'h4
   } pti_dir_t;

   // -------------------------------------------------------------------
   // State records
   // -------------------------------------------------------------------
   typedef struct packed
   {
      logic near_event_flag;
      logic far_event_flag;
      logic sunlight_guard_flag;
      pti_dir_t last_dir;
      logic int_n;
      logic [`PTI_DATA_W-1:0] rd_data;
      logic rd_valid;
   } pti_state_t;

   typedef struct packed
   {
      logic [`PTI_CNT_W-1:0] count;
      logic fire;
   } pti_pers_state_t;

endpackage

// ### sim/proximity_threshold_interrupt_tb.sv
/* Bench of pti_core against an integer model of flags and line;
 * assumes the pti_host model and pti_params.svh. */
`include "pti_params.svh"
module proximity_threshold_interrupt_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'h0, nrst = 1'h0, mv = 1'h0, me = 1'h0, sun = 1'h0;
   logic rs, rv, intn;
   logic [1:0] pc = 2'h0;
   logic [7:0] ra;
   logic [15:0] md = 16'h0000, rd, got;
   logic [15:0] th = 16'h8000, tl = 16'h4000;
   int seed = 35700, miscompares = 0, cmp_count = 0, cycles = 0;
   int nf = 0, ff = 0, sf = 0, last = 0, cn = 0, cf = 0, i, k;
   pti_core dut
   (
      .MCLK(mclk), .NRST(nrst), .MEAS_VALID(mv), .MEAS_DATA(md),
      .THRESH_HIGH(th), .THRESH_LOW(tl), .MODE_ENABLE(me),
      .CROSSING_PERSISTENCE_COUNT(pc), .SUNLIGHT_EVENT(sun),
      .RD_STROBE(rs), .RD_ADDR(ra), .RD_DATA(rd), .RD_VALID(rv),
      .INT_N(intn)
   );
   pti_host host
   (
      .clk(mclk), .rd_strobe(rs), .rd_addr(ra), .rd_valid(rv), .rd_data(rd)
   );
   initial
      forever #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
         report_and_stop();
   end
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      miscompares += cycles >= 5000;
      $display("Compared %0d mismatched %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic void fire(int dir);
      nf |= dir == 1;
      ff |= dir == 2;
      last = dir;
   endfunction
   function automatic logic [15:0] line();
      return 16'(me ? !(nf || ff || sf) : last != 1);
   endfunction
   // One measurement, maybe a sunlight event, then one host read
   task automatic cycle(logic [15:0] d, logic [7:0] a);
      logic f9;
      logic [15:0] e;
      f9 = a == `PTI_FLAG_ADDR;
      @(posedge mclk) #1;
      md = d;
      mv = 1'h1;
      @(posedge mclk) #1;
      mv = 1'h0;
      md = ~d;
      cn = d > th ? cn + 1 : 0;
      cf = d < tl ? cf + 1 : 0;
      if (cn == pc + 1 && (me || last != 1))
         fire(1);
      if (cf == pc + 1 && (me || last != 2))
         fire(2);
      repeat (2) @(posedge mclk) #1;
      check("int_n", intn, line());
      sun = 1'($random(seed));
      sf |= sun;
      @(posedge mclk) #1;
      sun = 1'h0;
      e = 16'(nf << 9 | ff << 8 | sf << 12) & {16{f9}};
      host.read(a, got);
      check("flags", got, e);
      sf = f9 ? 0 : sf;
      nf = f9 && me ? 0 : nf;
      ff = f9 && me ? 0 : ff;
      check("int_n", intn, line());
   endtask
   initial
   begin
      repeat (8) @(posedge mclk) #1;
      nrst = 1'h1;
      check("int_n", intn, 16'h0001);
      for (k = 0; k < 8; k++)
      begin
         me = k > 3;
         pc = 2'(k);
         // Thresholds move per pass; 16'h6000 stays between them
         th = 16'h8000 | 16'($random(seed)) & 16'h0FFF;
         tl = 16'h4000 | 16'($random(seed)) & 16'h0FFF;
         // A quiet sample restarts both runs right after the count changes
         cycle(16'h6000, `PTI_FLAG_ADDR);
         for (i = 0; i < 14; i++)
            cycle(i % 6 == 5 ? 16'h6000 : 16'($random(seed)),
               i % 3 ? `PTI_FLAG_ADDR : 8'($random(seed)));
      end
      host.read(`PTI_FLAG_ADDR, got);
      host.read(`PTI_FLAG_ADDR, got);
      check("cleared", got, 16'h0000);
      // Let the checker finish properties that end after the last read
      repeat (2) @(posedge mclk) #1;
      report_and_stop();
   end
endmodule

// ### sim/pti_checker.sv
/* Port checker of pti_core, bound below; assumes one MCLK domain and
 * NRST synchronous, active low. */
`include "pti_params.svh"
module pti_checker
(
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic MEAS_VALID,
   input wire logic [`PTI_DATA_W-1:0] MEAS_DATA,
   input wire logic [`PTI_DATA_W-1:0] THRESH_HIGH,
   input wire logic [`PTI_DATA_W-1:0] THRESH_LOW,
   input wire logic MODE_ENABLE,
   input wire logic [`PTI_PERS_W-1:0] CROSSING_PERSISTENCE_COUNT,
   input wire logic SUNLIGHT_EVENT,
   input wire logic RD_STROBE,
   input wire logic [`PTI_ADDR_W-1:0] RD_ADDR,
   input wire logic [`PTI_DATA_W-1:0] RD_DATA,
   input wire logic RD_VALID,
   input wire logic INT_N
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!NRST);
   sequence s_rd;
      RD_STROBE && RD_ADDR == `PTI_FLAG_ADDR;
   endsequence
   property p_ans;
      RD_STROBE |=> RD_VALID;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_unm;
      RD_STROBE && RD_ADDR != `PTI_FLAG_ADDR |=> RD_DATA == 16'h0000;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_idle;
      !RD_VALID |-> RD_DATA == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_bits;
      RD_VALID |-> (RD_DATA & 16'hECFF) == 16'h0000;
   endproperty
   a_bits: assert property (p_bits) else $error("spare bits");
   property p_sun;
      SUNLIGHT_EVENT ##1 !RD_STROBE ##1 s_rd |=> RD_DATA[`PTI_SUN_BIT];
   endproperty
   a_sun: assert property (p_sun) else $error("sun flag");
   // Quiet window keeps late sets from hiding a missing clear
   property p_clr;
      (!MEAS_VALID && !SUNLIGHT_EVENT) [*3] ##0 s_rd ##0 MODE_ENABLE
         ##1 (!MEAS_VALID && !SUNLIGHT_EVENT) [*2] ##0 s_rd
         |=> RD_DATA == 16'h0000;
   endproperty
   a_clr: assert property (p_clr) else $error("not cleared");
   property p_low;
      $fell(INT_N) && !MODE_ENABLE && !$past(MODE_ENABLE)
         && !$past(MODE_ENABLE, 2) |-> $past(MEAS_VALID, 2)
         && $past(MEAS_DATA, 2) > $past(THRESH_HIGH, 2);
   endproperty
   a_low: assert property (p_low) else $error("bad fall");
   property p_high;
      $rose(INT_N) && !MODE_ENABLE && !$past(MODE_ENABLE)
         && !$past(MODE_ENABLE, 2) |-> $past(MEAS_VALID, 2)
         && $past(MEAS_DATA, 2) < $past(THRESH_LOW, 2);
   endproperty
   a_high: assert property (p_high) else $error("bad rise");
endmodule
bind pti_core pti_checker chk
(
   .MCLK(MCLK), .NRST(NRST), .MEAS_VALID(MEAS_VALID), .MEAS_DATA(MEAS_DATA),
   .THRESH_HIGH(THRESH_HIGH), .THRESH_LOW(THRESH_LOW),
   .MODE_ENABLE(MODE_ENABLE), .SUNLIGHT_EVENT(SUNLIGHT_EVENT),
   .CROSSING_PERSISTENCE_COUNT(CROSSING_PERSISTENCE_COUNT),
   .RD_STROBE(RD_STROBE), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
   .RD_VALID(RD_VALID), .INT_N(INT_N)
);

// ### sim/pti_host.sv
/* Host model issuing register reads; assumes one caller at a time. */
module pti_host
(
   input wire logic clk,
   output logic rd_strobe = 1'h0,
   output logic [7:0] rd_addr = 8'h00,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // The flag read doubles as the event acknowledge
   task automatic read(logic [7:0] a, output logic [15:0] d);
      int n;
      @(posedge clk) #1;
      rd_strobe = 1'h1;
      rd_addr = a;
      @(posedge clk) #1;
      rd_strobe = 1'h0;
      // Released address inverts so a stale value never looks valid
      rd_addr = ~a;
      for (n = 0; n < 4 && rd_valid !== 1'h1; n++)
         @(posedge clk) #1;
      d = rd_data;
   endtask
endmodule
